// [hdl/lphy_cfg.svh]
// Offsets, field positions, reset values and timing counts of the bus phy control block.
`ifndef LPHY_CFG_SVH
`define LPHY_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define LPHY_BASE_BLOCKING 16'h0200
`define LPHY_BASE_NONBLOCK 16'h0300
`define LPHY_CSR_OFFSET 8'h18
`define LPHY_CSR_RESET 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define LPHY_BIT_IRQ_EN 7
`define LPHY_BIT_OT 6
`define LPHY_BIT_RX 5
`define LPHY_BIT_TX 4
`define LPHY_BIT_UVSD_DIS 3
`define LPHY_BIT_EN 2
`define LPHY_SLOPE_HI 1
`define LPHY_SLOPE_LO 0

// ****************************************************************
// Slope codes
// ****************************************************************
`define LPHY_SLOPE_NORM 2'h0
`define LPHY_SLOPE_SLOW 2'h1
`define LPHY_SLOPE_FAST 2'h2
`define LPHY_SLOPE_NORM2 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define LPHY_CLK_MHZ 100
`define LPHY_WAKE_FILTER_US 80
`define LPHY_WAKE_FILTER_CYC (`LPHY_WAKE_FILTER_US * `LPHY_CLK_MHZ)

`endif

// [hdl/lphy_pkg.sv]
// Types shared by the bus phy control block.
package lphy_pkg;

	typedef enum logic [1:0] {
		LPHY_SLOPE_20K = 2'h0,
		LPHY_SLOPE_10K = 2'h1,
		LPHY_SLOPE_100K = 2'h2
	} lphy_slope_t;

	// Register bus request from the die-to-die target.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lphy_req_t;

	// Analog status inputs.
	typedef struct packed {
		logic overtemp;
		logic undervolt;
		logic low_power;
	} lphy_ana_t;

	typedef enum logic [1:0] {
		LPHY_UV_RUN = 2'h0,
		LPHY_UV_WAIT_REC = 2'h1,
		LPHY_UV_HOLD = 2'h3,
		LPHY_UV_WAIT_RES = 2'h2
	} lphy_uv_t;

	typedef enum logic [1:0] {
		LPHY_WK_IDLE = 2'h0,
		LPHY_WK_DOM = 2'h1,
		LPHY_WK_LONG = 2'h3
	} lphy_wk_t;

endpackage

// [hdl/lphy_ctrl.sv]
// Digital control and status logic of the single-wire bus physical layer.
`include "lphy_cfg.svh"

module lphy_ctrl import lphy_pkg::*; #(
	parameter int WAKE_FILTER_CYC = `LPHY_WAKE_FILTER_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire lphy_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire lphy_ana_t ana,
	input wire logic txd,
	input wire logic bus_rx,
	output logic drive_dom,
	output logic rxd,
	output logic [1:0] slope,
	output logic irq,
	output logic wake
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic irq_en_q, irq_en_d;
	logic tx_dir_q, tx_dir_d;
	logic uvsd_dis_q, uvsd_dis_d;
	logic en_q, en_d;
	logic [1:0] slope_sel_q, slope_sel_d;
	logic ot_q, ot_d;
	logic ot_lock_q, ot_lock_d;
	logic irq_q, irq_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic tx_q, tx_d;
	logic tx_hold_q, tx_hold_d;
	lphy_uv_t uv_q, uv_d;
	lphy_wk_t wk_q, wk_d;
	logic [31:0] wk_cnt_q, wk_cnt_d;
	logic wake_q, wake_d;
	logic drive_q, drive_d;
	logic rxd_q, rxd_d;
	logic [1:0] slope_q, slope_d;
	logic hit;
	logic [7:0] csr_view;
	logic tx_want;
	logic uv_block;

	// ****************************************************************
	// Register port
	// ****************************************************************
	// offset decode
	assign hit = (req.addr == `LPHY_CSR_OFFSET);

	always_comb begin
		csr_view = 8'h00;
		csr_view[`LPHY_BIT_IRQ_EN] = irq_en_q;
		csr_view[`LPHY_BIT_OT] = ot_q;
		csr_view[`LPHY_BIT_RX] = bus_rx;
		csr_view[`LPHY_BIT_TX] = tx_dir_q;
		csr_view[`LPHY_BIT_UVSD_DIS] = uvsd_dis_q;
		csr_view[`LPHY_BIT_EN] = en_q;
		csr_view[`LPHY_SLOPE_HI:`LPHY_SLOPE_LO] = slope_sel_q;
	end

	always_comb begin
		irq_en_d = irq_en_q;
		tx_dir_d = tx_dir_q;
		uvsd_dis_d = uvsd_dis_q;
		en_d = en_q;
		slope_sel_d = slope_sel_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (req.wr && hit) begin
			irq_en_d = req.wdata[`LPHY_BIT_IRQ_EN];
			tx_dir_d = req.wdata[`LPHY_BIT_TX];
			uvsd_dis_d = req.wdata[`LPHY_BIT_UVSD_DIS];
			en_d = req.wdata[`LPHY_BIT_EN];
			slope_sel_d = req.wdata[`LPHY_SLOPE_HI:`LPHY_SLOPE_LO];
		end
		if (req.rd) begin
			rvalid_d = 1'b1;
			rdata_d = hit ? csr_view : 8'h00;
		end
	end

	// ****************************************************************
	// Overtemperature and interrupt
	// ****************************************************************
	always_comb begin
		ot_d = ana.overtemp;
		ot_lock_d = ot_lock_q;
		irq_d = irq_q;
		if (req.rd && hit) begin
			irq_d = 1'b0;
		end
		if (!ana.overtemp) begin
			ot_lock_d = 1'b0;
		end
		// raise on entry, set beats clear
		if (ana.overtemp && !ot_lock_q) begin
			ot_lock_d = 1'b1;
			if (irq_en_q) begin
				irq_d = 1'b1;
			end
		end
		if (!irq_en_q) begin
			irq_d = 1'b0;
		end
	end

	// ****************************************************************
	// Transmit path
	// ****************************************************************
	// direct bit ORed with path
	assign tx_want = !txd || tx_dir_q;

	// After overheating the driver stays off until transmit data is recessive.
	// A stuck dominant input therefore cannot restart a driver that just cooled down.
	always_comb begin
		tx_hold_d = tx_hold_q;
		if (ana.overtemp) begin
			tx_hold_d = 1'b1;
		end else if (txd) begin
			tx_hold_d = 1'b0;
		end
	end

	always_comb begin
		uv_d = uv_q;
		case (uv_q)
			LPHY_UV_RUN: begin
				if (ana.undervolt && !uvsd_dis_q) begin
					uv_d = tx_q ? LPHY_UV_WAIT_REC : LPHY_UV_HOLD;
				end
			end
			LPHY_UV_WAIT_REC: begin
				if (!tx_want) begin
					uv_d = LPHY_UV_HOLD;
				end
			end
			LPHY_UV_HOLD: begin
				if (!ana.undervolt || uvsd_dis_q) begin
					uv_d = tx_want ? LPHY_UV_WAIT_RES : LPHY_UV_RUN;
				end
			end
			LPHY_UV_WAIT_RES: begin
				if (!tx_want) begin
					uv_d = LPHY_UV_RUN;
				end
			end
			default: begin
				uv_d = LPHY_UV_RUN;
			end
		endcase
	end

	assign uv_block = (uv_q == LPHY_UV_HOLD) || (uv_q == LPHY_UV_WAIT_RES);

	always_comb begin
		tx_d = tx_want;
		if (uv_q == LPHY_UV_WAIT_REC) begin
			tx_d = tx_want;
		end
		if (!en_q || ana.low_power || tx_hold_q || ana.overtemp || uv_block) begin
			tx_d = 1'b0;
		end
		drive_d = tx_d;
		rxd_d = en_q ? bus_rx : 1'b1;
		case (slope_sel_q)
			`LPHY_SLOPE_SLOW: slope_d = LPHY_SLOPE_10K;
			`LPHY_SLOPE_FAST: slope_d = LPHY_SLOPE_100K;
			default: slope_d = LPHY_SLOPE_20K;
		endcase
	end

	// ****************************************************************
	// Wake-up detection
	// ****************************************************************
	// The counter runs only while the bus stays dominant in low power.
	always_comb begin
		wk_d = wk_q;
		wk_cnt_d = wk_cnt_q;
		wake_d = 1'b0;
		case (wk_q)
			LPHY_WK_IDLE: begin
				wk_cnt_d = 32'h0;
				if (ana.low_power && !bus_rx) begin
					wk_d = LPHY_WK_DOM;
				end
			end
			LPHY_WK_DOM: begin
				wk_cnt_d = wk_cnt_q + 32'h1;
				if (!ana.low_power || bus_rx) begin
					wk_d = LPHY_WK_IDLE;
				end else if (wk_cnt_q >= 32'(WAKE_FILTER_CYC)) begin
					wk_d = LPHY_WK_LONG;
				end
			end
			LPHY_WK_LONG: begin
				if (!ana.low_power) begin
					wk_d = LPHY_WK_IDLE;
				end else if (bus_rx) begin
					wake_d = 1'b1;
					wk_d = LPHY_WK_IDLE;
				end
			end
			default: begin
				wk_d = LPHY_WK_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_en_q <= 1'b0;
			tx_dir_q <= 1'b0;
			uvsd_dis_q <= 1'b0;
			en_q <= 1'b0;
			slope_sel_q <= 2'h0;
			ot_q <= 1'b0;
			ot_lock_q <= 1'b0;
			irq_q <= 1'b0;
			rdata_q <= `LPHY_CSR_RESET;
			rvalid_q <= 1'b0;
			tx_q <= 1'b0;
			tx_hold_q <= 1'b0;
			uv_q <= LPHY_UV_RUN;
			wk_q <= LPHY_WK_IDLE;
			wk_cnt_q <= 32'h0;
			wake_q <= 1'b0;
			drive_q <= 1'b0;
			rxd_q <= 1'b1;
			slope_q <= 2'h0;
		end else begin
			irq_en_q <= irq_en_d;
			tx_dir_q <= tx_dir_d;
			uvsd_dis_q <= uvsd_dis_d;
			en_q <= en_d;
			slope_sel_q <= slope_sel_d;
			ot_q <= ot_d;
			ot_lock_q <= ot_lock_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			tx_q <= tx_d;
			tx_hold_q <= tx_hold_d;
			uv_q <= uv_d;
			wk_q <= wk_d;
			wk_cnt_q <= wk_cnt_d;
			wake_q <= wake_d;
			drive_q <= drive_d;
			rxd_q <= rxd_d;
			slope_q <= slope_d;
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign drive_dom = drive_q;
	assign rxd = rxd_q;
	assign slope = slope_q;
	assign irq = irq_q;
	assign wake = wake_q;

endmodule // lphy_ctrl

// [test/lphy_ctrl_checker.sv]
// Port assertions of the bus phy control block.
`include "lphy_cfg.svh"
module lphy_ctrl_checker import lphy_pkg::*; #(
	parameter int WAKE_FILTER_CYC = `LPHY_WAKE_FILTER_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire lphy_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire lphy_ana_t ana,
	input wire logic txd,
	input wire logic bus_rx,
	input wire logic drive_dom,
	input wire logic rxd,
	input wire logic [1:0] slope,
	input wire logic irq,
	input wire logic wake
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_hot; ana.overtemp |=> !drive_dom; endproperty
	a_hot: assert property (p_hot) else $error("driver on while hot");
	property p_irq; $rose(irq) |-> $past(ana.overtemp); endproperty
	a_irq: assert property (p_irq) else $error("irq without heat");
	property p_ack; req.rd && req.addr == 8'h18 && !ana.overtemp && !$past(ana.overtemp)
		|=> !irq; endproperty
	a_ack: assert property (p_ack) else $error("irq kept after read");
	property p_rpt; !irq && ana.overtemp && $past(ana.overtemp) && $past(ana.overtemp, 2)
		|=> !irq; endproperty
	a_rpt: assert property (p_rpt) else $error("repeat irq");
	property p_low; ana.low_power |=> !drive_dom; endproperty
	a_low: assert property (p_low) else $error("driver on in low power");
	property p_wake; wake |-> $past(bus_rx) && !$past(bus_rx, 2) && $past(ana.low_power);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without edge");
	property p_rx; rvalid && $past(req.addr) == 8'h18 |-> rdata[5] == $past(bus_rx); endproperty
	a_rx: assert property (p_rx) else $error("rx bit wrong");
	property p_map; rvalid && $past(req.addr) != 8'h18 |-> rdata == 8'h00; endproperty
	a_map: assert property (p_map) else $error("unmapped read not zero");
	property p_rdv; rvalid == $past(req.rd); endproperty
	a_rdv: assert property (p_rdv) else $error("read answer not one cycle after request");
	c_irq: cover property ($rose(irq));
	c_wake: cover property (wake);
	c_uv: cover property (ana.undervolt && drive_dom);
endmodule // lphy_ctrl_checker
bind lphy_ctrl lphy_ctrl_checker #(.WAKE_FILTER_CYC(WAKE_FILTER_CYC)) lphy_ctrl_checker_i (
	.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
	.ana(ana), .txd(txd), .bus_rx(bus_rx), .drive_dom(drive_dom), .rxd(rxd),
	.slope(slope), .irq(irq), .wake(wake));

// [test/lphy_bus_model.sv]
// Single-wire bus with its pull-up and one other node.
module lphy_bus_model (
	input wire logic drive_dom,
	input wire logic other_dom,
	output logic bus_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	// The pull-up holds the line recessive unless some node pulls it low.
	assign bus_rx = !(drive_dom || other_dom);
endmodule // lphy_bus_model

// [test/testbench.sv]
// Self-checking bench of the bus phy control block.
module testbench import lphy_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0] w;
		logic t;
		logic [1:0] s;
		logic d;
		logic [7:0] r;
	} lphy_row_t;
	lphy_row_t rows [6] = '{'{8'h04, 1'b1, 2'h0, 1'b0, 8'h24}, '{8'h05, 1'b0, 2'h1, 1'b1, 8'h05},
		'{8'h06, 1'b1, 2'h2, 1'b0, 8'h26}, '{8'h07, 1'b0, 2'h0, 1'b1, 8'h07},
		'{8'h14, 1'b1, 2'h0, 1'b1, 8'h14}, '{8'h70, 1'b0, 2'h0, 1'b0, 8'h30}};
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	lphy_req_t req = '0;
	lphy_ana_t ana = '0;
	logic txd = 1'b1;
	logic other_dom = 1'b0;
	logic bus_rx, drive_dom, rxd, irq, wake, rvalid;
	logic [7:0] rdata;
	logic [1:0] slope;
	int fail_count = 0;
	int tests_run = 0;
	int n, k;
	lphy_ctrl #(.WAKE_FILTER_CYC(20)) lphy_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.req(req), .rdata(rdata), .rvalid(rvalid), .ana(ana), .txd(txd), .bus_rx(bus_rx),
		.drive_dom(drive_dom), .rxd(rxd), .slope(slope), .irq(irq), .wake(wake));
	lphy_bus_model lphy_bus_model_i (.drive_dom(drive_dom), .other_dom(other_dom),
		.bus_rx(bus_rx));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task chk(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task rst();
		rst_b = 1'b0;
		cyc(10);
		rst_b = 1'b1;
	endtask
	// The host adds its base; the block sees only the offset.
	task wr(input logic [7:0] a, d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		cyc(1);
		req.wr = 1'b0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a, exp);
		req.rd = 1'b1;
		req.addr = a;
		cyc(1);
		req.rd = 1'b0;
		for (n = 0; n < 3 && rvalid !== 1'b1; n++) cyc(1);
		chk("rdata", rdata, exp);
		if (n == 3) begin
			chk("rvalid", 8'h00, 8'h01);
			stop_test();
		end
		cyc(1);
	endtask
	task uvd(input logic d);
		txd = 1'b1;
		cyc(2);
		txd = 1'b0;
		cyc(3);
		chk("uv drive", 8'(drive_dom), 8'(d));
	endtask
	initial begin
		rst();
		foreach (rows[i]) begin
			txd = rows[i].t;
			wr(8'h18, rows[i].w);
			cyc(3);
			chk("slope", 8'(slope), 8'(rows[i].s));
			chk("drive", 8'(drive_dom), 8'(rows[i].d));
			chk("rxd", 8'(rxd), 8'(!rows[i].d));
			rd(8'h18, rows[i].r);
		end
		$display("done table");
		wr(8'h18, 8'h06);
		rst();
		chk("slope", 8'(slope), 8'h00);
		chk("irq", 8'(irq), 8'h00);
		rd(8'h18, 8'h20);
		$display("done reset");
		wr(8'h18, 8'h84);
		txd = 1'b0;
		ana.overtemp = 1'b1;
		cyc(3);
		chk("hot drive", 8'(drive_dom), 8'h00);
		chk("irq", 8'(irq), 8'h01);
		rd(8'h18, 8'hE4);
		chk("irq ack", 8'(irq), 8'h00);
		cyc(5);
		chk("irq hold", 8'(irq), 8'h00);
		ana.overtemp = 1'b0;
		cyc(3);
		chk("cool drive", 8'(drive_dom), 8'h00);
		uvd(1'b1);
		ana.overtemp = 1'b1;
		cyc(3);
		chk("irq again", 8'(irq), 8'h01);
		ana.overtemp = 1'b0;
		wr(8'h18, 8'h04);
		ana.overtemp = 1'b1;
		cyc(3);
		chk("irq masked", 8'(irq), 8'h00);
		ana.overtemp = 1'b0;
		wr(8'h19, 8'hFF);
		rd(8'h19, 8'h00);
		txd = 1'b1;
		rd(8'h18, 8'h24);
		$display("done heat");
		uvd(1'b1);
		ana.undervolt = 1'b1;
		cyc(3);
		chk("uv wait", 8'(drive_dom), 8'h01);
		uvd(1'b0);
		ana.undervolt = 1'b0;
		cyc(3);
		chk("uv end", 8'(drive_dom), 8'h00);
		uvd(1'b1);
		txd = 1'b1;
		cyc(2);
		ana.undervolt = 1'b1;
		uvd(1'b0);
		ana.undervolt = 1'b0;
		uvd(1'b1);
		wr(8'h18, 8'h0C);
		ana.undervolt = 1'b1;
		uvd(1'b1);
		ana.undervolt = 1'b0;
		$display("done supply");
		ana.low_power = 1'b1;
		cyc(2);
		chk("lp drive", 8'(drive_dom), 8'h00);
		for (k = 0; k < 2; k++) begin
			other_dom = 1'b1;
			cyc(k ? 25 : 5);
			chk("lp rxd", 8'(rxd), 8'h00);
			other_dom = 1'b0;
			n = 0;
			repeat (5) begin
				cyc(1);
				n += wake;
			end
			chk("wake", 8'(n), 8'(k));
		end
		$display("done wake");
		stop_test();
	end
endmodule // testbench
